// ### rtl/efnl_logger.v
// error first/next logger: tag capture, first/next records, poison tracking
`timescale 1ns/100ps
`default_nettype none
`include "efnl_defines.vh"
module efnl_logger #(
  parameter TW = 6,
  parameter NW = 8
) (
  input wire core_clk,
  input wire rstn,
  // power-on clear: records are sticky through rstn
  input wire por_n,
  // one line retired by the data path
  input wire line_vld,
  input wire [TW-1:0] line_tag,
  input wire [NW-1:0] line_sec,
  input wire [NW-1:0] line_ded,
  input wire line_fse,
  // retirement seen while bus-init is clearing queues
  input wire retire_vld,
  input wire fatal_bus_init,
  // expander data toward memory with parity error
  input wire xp_par_vld,
  // poisoned 8-byte transfer through expander port
  input wire xp_psn_vld,
  input wire xp_odd4,
  // remap table lookup fault
  input wire rm_inv_vld,
  input wire rm_illegal,
  // buffer line poison tracking
  input wire mem_rd_vld,
  input wire [NW-1:0] mem_rd_ded,
  input wire part_wr_vld,
  input wire full_wr_vld,
  input wire iwb_vld,
  input wire iwb_ded,
  input wire wb_vld,
  input wire fatal_bus_init_on_bad,
  // software controls
  input wire [2:0] cap_clr,
  input wire [2:0] cap_dis,
  input wire [3:0] ac_first_clr,
  input wire [3:0] ac_next_clr,
  input wire dc_clr,
  input wire [2:0] rm_clr,
  // status
  output reg [7:0] single_bit_tag_capture,
  output reg [7:0] double_bit_tag_capture,
  output reg [7:0] bus_error_tag_capture,
  output reg [3:0] addr_ctrl_first_error,
  output reg [3:0] addr_ctrl_next_error,
  output reg [2:0] data_ctrl_first_error,
  output reg [2:0] data_ctrl_next_error,
  output reg [TW-1:0] dc_log_tag,
  output reg [2:0] remap_table_first_error,
  output reg xp_first_q,
  output reg xp_next_q,
  output reg tag_retire_q,
  output reg [TW-1:0] retire_tag_q,
  output reg [NW-1:0] wb_poison_q,
  output reg wb_out_q,
  output reg fatal_req_q,
  output reg fwd_bridge_q
);

  // ****************************************
  // helpers
  // ****************************************
  localparam NC = NW / 2;

  function [NC-1:0] chunk_bad;
    input [NW-1:0] w;
    integer i;
    begin
      chunk_bad = {NC{1'b0}};
      for (i = 0; i < NC; i = i + 1) begin
        chunk_bad[i] = w[2*i] | w[2*i+1];
      end
    end
  endfunction

  function many;
    input [NC-1:0] v;
    begin
      many = ((v & (v - {{(NC-1){1'b0}}, 1'b1})) != {NC{1'b0}});
    end
  endfunction

  // ****************************************
  // line classification
  // ****************************************
  wire [NC-1:0] bad_ch = chunk_bad(line_sec | line_ded);
  wire any_ded = |line_ded;
  wire any_sec = |line_sec;
  wire line_err = line_vld & (any_ded | any_sec | line_fse);
  // double-bit wins, then bus error, then single-bit
  wire is_ded = any_ded;
  wire is_fse = line_fse & ~any_ded;
  wire is_sec = any_sec & ~any_ded & ~line_fse;

  reg [1:0] cap_idx;
  always @* begin
    if (is_ded) begin
      cap_idx = 2'd`EFNL_CAP_DED;
    end else if (is_fse) begin
      cap_idx = 2'd`EFNL_CAP_FSE;
    end else begin
      cap_idx = 2'd`EFNL_CAP_SEC;
    end
  end
  wire disabled = cap_dis[cap_idx];
  wire ac_evt = line_err & ~disabled;

  // ****************************************
  // tag capture registers
  // ****************************************
  wire [2:0] cap_hit;
  assign cap_hit[`EFNL_CAP_SEC] = ac_evt & is_sec;
  assign cap_hit[`EFNL_CAP_DED] = ac_evt & is_ded;
  assign cap_hit[`EFNL_CAP_FSE] = ac_evt & is_fse;

  function [7:0] cap_next;
    input [7:0] cur;
    input hit;
    input clr;
    input dis;
    input [TW-1:0] tag;
    reg [7:0] r;
    begin
      r = cur;
      r[`EFNL_CAP_DIS_BIT] = dis;
      if (clr) begin
        r[`EFNL_CAP_VALID_BIT] = 1'b0;
      end
      // first tag held; a same-cycle clear frees the slot for the new one
      if (hit & (~cur[`EFNL_CAP_VALID_BIT] | clr)) begin
        r[`EFNL_CAP_VALID_BIT] = 1'b1;
        r[TW-1:0] = tag;
      end
      cap_next = r;
    end
  endfunction

  always @(posedge core_clk) begin
    if (!por_n) begin
      single_bit_tag_capture <= 8'h00;
      double_bit_tag_capture <= 8'h00;
      bus_error_tag_capture <= 8'h00;
    end else begin
      single_bit_tag_capture <= cap_next(single_bit_tag_capture,
        cap_hit[`EFNL_CAP_SEC], cap_clr[`EFNL_CAP_SEC],
        cap_dis[`EFNL_CAP_SEC], line_tag);
      double_bit_tag_capture <= cap_next(double_bit_tag_capture,
        cap_hit[`EFNL_CAP_DED], cap_clr[`EFNL_CAP_DED],
        cap_dis[`EFNL_CAP_DED], line_tag);
      bus_error_tag_capture <= cap_next(bus_error_tag_capture,
        cap_hit[`EFNL_CAP_FSE], cap_clr[`EFNL_CAP_FSE],
        cap_dis[`EFNL_CAP_FSE], line_tag);
    end
  end

  // ****************************************
  // tag retirement
  // ****************************************
  reg [TW-1:0] rel_tag;
  reg rel;
  always @* begin
    rel = 1'b0;
    rel_tag = {TW{1'b0}};
    if (line_err & disabled) begin
      rel = 1'b1;
      rel_tag = line_tag;
    end else if (cap_clr[`EFNL_CAP_SEC]) begin
      rel = single_bit_tag_capture[`EFNL_CAP_VALID_BIT];
      rel_tag = single_bit_tag_capture[TW-1:0];
    end else if (cap_clr[`EFNL_CAP_DED]) begin
      rel = double_bit_tag_capture[`EFNL_CAP_VALID_BIT];
      rel_tag = double_bit_tag_capture[TW-1:0];
    end else if (cap_clr[`EFNL_CAP_FSE]) begin
      rel = bus_error_tag_capture[`EFNL_CAP_VALID_BIT];
      rel_tag = bus_error_tag_capture[TW-1:0];
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      tag_retire_q <= 1'b0;
      retire_tag_q <= {TW{1'b0}};
    end else begin
      tag_retire_q <= rel;
      retire_tag_q <= rel_tag;
    end
  end

  // ****************************************
  // address controller records
  // ****************************************
  reg [3:0] acf_d;
  reg [3:0] acn_d;
  always @* begin
    // clear first, so a same-cycle set wins
    acf_d = addr_ctrl_first_error & ~ac_first_clr;
    acn_d = addr_ctrl_next_error & ~ac_next_clr;
    if (ac_evt) begin
      if (addr_ctrl_first_error == 4'h0) begin
        if (is_sec) begin
          acf_d[`EFNL_AC_CORR] = 1'b1;
        end else begin
          acf_d[`EFNL_AC_GEN] = 1'b1;
        end
      end else if (!addr_ctrl_first_error[`EFNL_AC_GEN]) begin
        // first still takes a generic mark, it was not written as such
        acf_d[`EFNL_AC_GEN] = 1'b1;
      end else begin
        acn_d[`EFNL_AC_GEN] = 1'b1;
      end
    end
    if (retire_vld & fatal_bus_init) begin
      acn_d[`EFNL_AC_UNDF] = 1'b1;
    end
    if (xp_par_vld) begin
      if (addr_ctrl_first_error == 4'h0) begin
        acf_d[`EFNL_AC_XPAR] = 1'b1;
      end else begin
        acn_d[`EFNL_AC_XPAR] = 1'b1;
      end
      acn_d[`EFNL_AC_GEN] = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (!por_n) begin
      addr_ctrl_first_error <= `EFNL_AC_RST;
      addr_ctrl_next_error <= `EFNL_AC_RST;
    end else begin
      addr_ctrl_first_error <= acf_d;
      addr_ctrl_next_error <= acn_d;
    end
  end

  // ****************************************
  // data controller records and log
  // ****************************************
  // reports only single, double and bus data kinds: no fatal path
  wire [2:0] dc_kind = {line_fse, any_ded, any_sec};
  wire dc_evt = line_err & (bad_ch != {NC{1'b0}} | line_fse);
  wire dc_any = (data_ctrl_first_error != 3'h0);
  wire dc_lock = dc_any | (data_ctrl_next_error != 3'h0);
  reg [2:0] dcf_d;
  reg [2:0] dcn_d;
  always @* begin
    // one clear write empties both records
    dcf_d = dc_clr ? 3'h0 : data_ctrl_first_error;
    dcn_d = dc_clr ? 3'h0 : data_ctrl_next_error;
    if (dc_evt) begin
      if (!dc_any) begin
        dcf_d = dcf_d | dc_kind;
        if (many(bad_ch)) begin
          dcn_d = dcn_d | dc_kind;
        end
      end else begin
        dcn_d = dcn_d | dc_kind;
      end
    end
  end

  always @(posedge core_clk) begin
    if (!por_n) begin
      data_ctrl_first_error <= `EFNL_DC_RST;
      data_ctrl_next_error <= `EFNL_DC_RST;
      dc_log_tag <= {TW{1'b0}};
    end else begin
      data_ctrl_first_error <= dcf_d;
      data_ctrl_next_error <= dcn_d;
      if (dc_evt & ~dc_lock) begin
        dc_log_tag <= line_tag;
      end
    end
  end

  // ****************************************
  // remap and expander poison records
  // ****************************************
  always @(posedge core_clk) begin
    if (!por_n) begin
      remap_table_first_error <= `EFNL_RM_RST;
      xp_first_q <= 1'b0;
      xp_next_q <= 1'b0;
    end else begin
      remap_table_first_error <= (remap_table_first_error & ~rm_clr)
        | {rm_inv_vld, rm_inv_vld & rm_illegal, 1'b0};
      if (xp_psn_vld) begin
        xp_first_q <= 1'b1;
        // aligned transfer: second 4-byte half is a second error
        xp_next_q <= xp_first_q | ~xp_odd4 | (xp_next_q & ~ac_next_clr[`EFNL_AC_XPAR]);
      end else begin
        xp_first_q <= xp_first_q & ~ac_first_clr[`EFNL_AC_XPAR];
        xp_next_q <= xp_next_q & ~ac_next_clr[`EFNL_AC_XPAR];
      end
    end
  end

  // ****************************************
  // buffer line poison marks
  // ****************************************
  reg [NW-1:0] mark_q;
  reg [NW-1:0] mark_d;
  always @* begin
    mark_d = mark_q;
    if (mem_rd_vld) begin
      // also covers a speculative read ahead of the snoop result
      mark_d = mark_q | mem_rd_ded;
    end
    if (part_wr_vld) begin
      mark_d = mark_d;
    end
    if (full_wr_vld) begin
      // writeback data is unused, yet a bad one still poisons
      mark_d = (iwb_vld & iwb_ded) ? {NW{1'b1}} : {NW{1'b0}};
    end else if (iwb_vld & iwb_ded) begin
      mark_d = {NW{1'b1}};
    end
    if (wb_vld) begin
      mark_d = {NW{1'b0}};
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      mark_q <= {NW{1'b0}};
      wb_poison_q <= {NW{1'b0}};
      wb_out_q <= 1'b0;
      fatal_req_q <= 1'b0;
      fwd_bridge_q <= 1'b0;
    end else begin
      mark_q <= mark_d;
      wb_out_q <= wb_vld;
      // whole 8-byte words carry the bad mark
      wb_poison_q <= wb_vld ? (mark_q | (iwb_vld & iwb_ded ? {NW{1'b1}} : {NW{1'b0}}))
        : {NW{1'b0}};
      fatal_req_q <= line_vld & line_fse & fatal_bus_init_on_bad;
      fwd_bridge_q <= line_vld & line_fse & ~fatal_bus_init_on_bad;
    end
  end

endmodule // efnl_logger
`default_nettype wire

// ### rtl/efnl_defines.vh
// constants and field layout for the error first/next logger
// Operation
// - Writing one to capture bit 6 clears the record and releases the tag; code releases one per cycle, disabled line first, then single, double, bus.
// - Data buffer checked per 16-byte chunk; several bad chunks set first and next.
// - ECC per 8-byte word; both words bad in a chunk is one error.
// - One indication per line sets address first, or next once first has generic set.
// - Later double-bit lines report only as generic non-fatal errors.
// - Second single-bit sets generic in first; more set generic in next.
// - Single-bit-only line stores tag in single capture, sets correctable flag.
// - Any double-bit line stores tag in double capture, sets generic only.
// - Bus data error without double-bit stores bus tag, sets generic only.
// - Retirement during fatal bus-init may flag underflow in next record.
// - Expander parity to memory: first gets parity, next gets generic poisoned.
// - Invalid remap entry sets bit 2; illegal untranslated address sets bit 1. Code sets bit 1 only with rm_inv_vld, so bit 2 is set too.
// - Poisoned data gives a whole 8-byte word bad parity.
// - Expander checks 4-byte units; aligned 8 bytes set first and next.
// - Double-bit marked word stays marked after full partial overwrite.
// - Full-line write overwrites a double-bit line with no report.
// - Writeback double-bit during expander full-line write poisons the line.
// - Speculative read double-bit marks line; later writeback goes poisoned.
// - Data controller reports single, double or bus data only, never fatal.
// - Bad incoming data goes poisoned; address side raises bus-init or forwards.
// - Capture bit 7 disables capture: tag retires, no address record raised; data records still set.
// - Data log locks while its first or next bit is set.
`ifndef EFNL_DEFINES_VH
`define EFNL_DEFINES_VH
// capture register fields
`define EFNL_CAP_VALID_BIT 6
`define EFNL_CAP_DIS_BIT 7
// capture index
`define EFNL_CAP_SEC 0
`define EFNL_CAP_DED 1
`define EFNL_CAP_FSE 2
// address controller record bits
`define EFNL_AC_CORR 0
`define EFNL_AC_GEN 1
`define EFNL_AC_XPAR 2
`define EFNL_AC_UNDF 3
// data controller record bits
`define EFNL_DC_SEC 0
`define EFNL_DC_DED 1
`define EFNL_DC_FSE 2
// remap record bits
`define EFNL_RM_ILL 1
`define EFNL_RM_INV 2
// reset values
`define EFNL_AC_RST 4'h0
`define EFNL_DC_RST 3'h0
`define EFNL_RM_RST 3'h0
`endif

// ### dv/efnl_logger_asserts.sv
// assertion checker for the error first/next logger
`timescale 1ns/100ps
`default_nettype none
module efnl_logger_asserts #(
  parameter TW = 6,
  parameter NW = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic line_vld,
  input wire logic [TW-1:0] line_tag,
  input wire logic [NW-1:0] line_sec,
  input wire logic [NW-1:0] line_ded,
  input wire logic line_fse,
  input wire logic [2:0] cap_clr,
  input wire logic [2:0] cap_dis,
  input wire logic [3:0] ac_first_clr,
  input wire logic dc_clr,
  input wire logic xp_psn_vld,
  input wire logic xp_odd4,
  input wire logic rm_inv_vld,
  input wire logic rm_illegal,
  input wire logic [7:0] single_bit_tag_capture,
  input wire logic [7:0] double_bit_tag_capture,
  input wire logic [3:0] addr_ctrl_first_error,
  input wire logic [2:0] data_ctrl_first_error,
  input wire logic [2:0] data_ctrl_next_error,
  input wire logic [TW-1:0] dc_log_tag,
  input wire logic [2:0] remap_table_first_error,
  input wire logic xp_first_q,
  input wire logic xp_next_q,
  input wire logic tag_retire_q,
  input wire logic [TW-1:0] retire_tag_q
);
  wire sec_only = line_vld && |line_sec && line_ded == 0 && !line_fse;
  wire dc_set = |data_ctrl_first_error || |data_ctrl_next_error;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !por_n);
  // ****************************************
  // capture, records and logs
  // ****************************************
  sec_capture_a: assert property (
    sec_only && !cap_dis[0] && !single_bit_tag_capture[6] |=> single_bit_tag_capture[6] &&
    single_bit_tag_capture[TW-1:0] == $past(line_tag)) else $error("single-bit tag not held");
  ded_capture_a: assert property (
    line_vld && |line_ded && !cap_dis[1] && !double_bit_tag_capture[6] &&
    addr_ctrl_first_error == 0 |=> double_bit_tag_capture[TW-1:0] == $past(line_tag) &&
    addr_ctrl_first_error == 4'h2) else $error("double-bit line logged wrongly");
  cap_release_a: assert property (
    cap_clr[0] && single_bit_tag_capture[6] && !line_vld |=> tag_retire_q && 
    retire_tag_q == $past(single_bit_tag_capture[TW-1:0]) && !single_bit_tag_capture[6])
    else $error("capture clear did not release tag");
  dis_retire_a: assert property (
    sec_only && cap_dis[0] && ac_first_clr == 0 |=> tag_retire_q &&
    retire_tag_q == $past(line_tag) && $stable(addr_ctrl_first_error))
    else $error("disabled capture still logged");
  remap_pair_a: assert property (
    rm_inv_vld |=> remap_table_first_error[2] && (remap_table_first_error[1] || !$past(rm_illegal)))
    else $error("remap record bits wrong");
  xp_aligned_a: assert property (
    xp_psn_vld && !xp_odd4 |=> xp_first_q && xp_next_q) else $error("aligned poison not doubled");
  dc_log_lock_a: assert property (
    dc_set && !dc_clr |=> $stable(dc_log_tag)) else $error("data log overwritten while locked");
  first_sticky_a: assert property (
    $past(por_n) |-> (~addr_ctrl_first_error & $past(addr_ctrl_first_error) &
    ~$past(ac_first_clr)) == 4'h0) else $error("first record lost without clear");
  cover property (line_vld && |line_ded);
  cover property (tag_retire_q);
  cover property (xp_next_q);
endmodule // efnl_logger_asserts
bind efnl_logger efnl_logger_asserts #(.TW(TW), .NW(NW)) u_chk (.*);
`default_nettype wire

// ### dv/efnl_logger_tb.sv
// self-checking bench for the error first/next logger
`timescale 1ns/100ps
`default_nettype none
module efnl_logger_tb;
  logic core_clk, rstn, por_n, line_vld, line_fse, retire_vld, fatal_bus_init, xp_par_vld;
  logic xp_psn_vld, xp_odd4, rm_inv_vld, rm_illegal, mem_rd_vld, part_wr_vld, full_wr_vld;
  logic iwb_vld, iwb_ded, wb_vld, fatal_bus_init_on_bad, dc_clr, f, s, d, b;
  logic xp_first_q, xp_next_q, tag_retire_q, wb_out_q, fatal_req_q, fwd_bridge_q;
  logic [5:0] line_tag, dc_log_tag, retire_tag_q, t;
  logic [7:0] line_sec, line_ded, mem_rd_ded, wb_poison_q, e;
  logic [2:0] cap_clr, cap_dis, rm_clr, data_ctrl_first_error, data_ctrl_next_error;
  logic [2:0] remap_table_first_error;
  logic [3:0] ac_first_clr, ac_next_clr, addr_ctrl_first_error, addr_ctrl_next_error;
  logic [7:0] single_bit_tag_capture, double_bit_tag_capture, bus_error_tag_capture;
  wire [7:0] cap [3];
  int fail_count, n_checks, seed, k;
  assign cap[0] = single_bit_tag_capture;
  assign cap[1] = double_bit_tag_capture;
  assign cap[2] = bus_error_tag_capture;
  efnl_logger #(.TW(6), .NW(8)) DUT (.*);
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // pulses drop by nba on the edge, so a new pulse one ns later never races them
  task tick;
    @(posedge core_clk);
    {line_vld, retire_vld, xp_par_vld, xp_psn_vld, rm_inv_vld, mem_rd_vld, part_wr_vld} <= '0;
    {full_wr_vld, iwb_vld, wb_vld, dc_clr, cap_clr, ac_first_clr, ac_next_clr, rm_clr} <= '0;
    fatal_bus_init_on_bad <= 1'($random(seed));
    #1;
  endtask
  task automatic line(input logic [5:0] tg, input logic [7:0] sc, dd, input logic fs);
    {line_tag, line_sec, line_ded, line_fse, line_vld} = {tg, sc, dd, fs, 1'b1};
    tick;
  endtask
  task clr_all; // firmware clearing order
    cap_clr = 3'h7;
    tick;
    ac_next_clr = 4'hf;
    tick;
    ac_first_clr = 4'hf;
    tick;
    {dc_clr, rm_clr} = 4'hf;
    tick;
    chk({addr_ctrl_first_error, addr_ctrl_next_error}, 8'h00);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    test_done;
  end
  initial begin
    {rstn, por_n, line_vld, line_fse, retire_vld, fatal_bus_init, xp_par_vld, xp_psn_vld} = '0;
    {xp_odd4, rm_inv_vld, rm_illegal, mem_rd_vld, part_wr_vld, full_wr_vld, iwb_vld} = '0;
    {iwb_ded, wb_vld, fatal_bus_init_on_bad, dc_clr, line_tag, line_sec, line_ded, mem_rd_ded} = '0;
    {cap_clr, cap_dis, rm_clr, ac_first_clr, ac_next_clr} = '0;
    seed = 57;
    repeat (2) tick;
    {rstn, por_n} = 2'b11;
    tick;
    {xp_psn_vld, xp_odd4} = 2'b11;
    tick;
    chk({4'h0, addr_ctrl_first_error}, 8'h00);
    chk(8'({xp_first_q, xp_next_q}), 8'h02);
    {xp_psn_vld, xp_odd4} = 2'b10;
    tick;
    chk(8'({xp_first_q, xp_next_q}), 8'h03);
    // every bus/single/double mix on one chunk
    for (int i = 0; i < 8; i++) begin
      {f, s, d} = 3'(i);
      clr_all;
      t = 6'($random(seed));
      b = fatal_bus_init_on_bad;
      line(t, {7'h0, s}, {6'h0, d, 1'b0}, f);
      k = d ? 1 : (f ? 2 : (s ? 0 : 3));
      e = (s && !f && !d) ? 8'h01 : ((f || s || d) ? 8'h02 : 8'h00);
      chk(8'(addr_ctrl_first_error), e);
      chk(8'(data_ctrl_next_error), 8'h00);
      chk(8'(data_ctrl_first_error), {5'h00, f, d, s});
      chk(8'({fatal_req_q, fwd_bridge_q}), f ? (b ? 8'h02 : 8'h01) : 8'h00);
      if (k < 3) begin
        chk(cap[k], {2'b01, t});
        cap_clr = 3'(1 << k);
        tick;
        chk({tag_retire_q, 1'b0, retire_tag_q}, {2'b10, t});
      end
    end
    // a later double-bit line lands only as generic in next
    line(t, 8'h00, 8'h02, 0);
    chk({addr_ctrl_first_error, addr_ctrl_next_error}, 8'h22);
    clr_all;
    for (int i = 0; i < 3; i++)
      line(6'(t + i), 8'h01, 8'h00, 0);
    chk({addr_ctrl_first_error, addr_ctrl_next_error}, 8'h32);
    chk({2'b00, cap[0][5:0]}, {2'b00, t});
    chk({2'b00, dc_log_tag}, {2'b00, t});
    rstn = 0;
    repeat (2) tick;
    rstn = 1;
    tick;
    chk(8'(addr_ctrl_first_error), 8'h03);
    clr_all;
    line(t, 8'h05, 8'h00, 0);
    chk(8'({|data_ctrl_first_error, |data_ctrl_next_error}), 8'h03);
    clr_all;
    cap_dis = 3'h1;
    line(t, 8'h01, 8'h00, 0);
    cap_dis = 0;
    chk({tag_retire_q, 1'b0, retire_tag_q}, {2'b10, t});
    chk({addr_ctrl_first_error, 3'h0, single_bit_tag_capture[7]}, 8'h01);
    clr_all;
    {retire_vld, fatal_bus_init, xp_par_vld, rm_inv_vld, rm_illegal} = 5'h1e;
    tick;
    fatal_bus_init = 0;
    chk({addr_ctrl_first_error, addr_ctrl_next_error}, 8'h4a);
    chk(8'(remap_table_first_error), 8'h04);
    rm_clr = 3'h7;
    tick;
    {rm_inv_vld, rm_illegal} = 2'b11;
    tick;
    chk(8'(remap_table_first_error), 8'h06);
    // buffer poison marks: partial keeps, full line drops, writeback re-marks
    {mem_rd_vld, mem_rd_ded} = {1'b1, 8'h04};
    tick;
    part_wr_vld = 1;
    tick;
    wb_vld = 1;
    tick;
    chk({wb_out_q, wb_poison_q[6:0]}, 8'h84);
    mem_rd_vld = 1;
    tick;
    full_wr_vld = 1;
    tick;
    wb_vld = 1;
    tick;
    chk(wb_poison_q, 8'h00);
    {full_wr_vld, iwb_vld, iwb_ded} = 3'h7;
    tick;
    wb_vld = 1;
    tick;
    chk(wb_poison_q, 8'hff);
    test_done;
  end
endmodule // efnl_logger_tb
`default_nettype wire
